// ---- shared/msli_pkg.sv ----
// Behaviour
// RL1: Flicker toggles lamp every 0.1 second
// RL2: Blink toggles lamp every 0.5 second
// RL3: Flash groups separated by 2 second gap
// RL4: Drive lamp dark, green, or blinking green
// RL5: Watchdog fault shows triple red flash
// RL6: Latched fault or no enable: steady red
// RL7: Busy lamp dark idle, green when moving
// RL8: Busy flashes fault code while drive red
// RL9: USB lamp green, red flash, steady red
// RL10: No program, limits low: travel fault red
// RL11: No program, limits high: red 500ms, green
// RL12: Limit-disable program: red 500ms, green
// RL13: Codes 8, 9, 10 for limits
// RL14: Codes 2 to 7; code 1 unused
// RL15: Code 11 for software negative limit
// RL16: Busy dark 2 seconds before each sequence
// RL17: Prescaled timing; reset clears all lamps
// RL18: Fault code repeats while fault latched
package msli_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_HZ          = 125000000;  // Reference clock rate
	localparam int unsigned TICK_US         = 1000;       // Base tick period, 1 ms
	localparam int unsigned TICK_CYC        = CLK_HZ / 1000000 * TICK_US;
	localparam int unsigned FLICKER_MS      = 100;        // 0.1 s per state
	localparam int unsigned BLINK_MS        = 500;        // 0.5 s per state
	localparam int unsigned FLASH_ON_MS     = 250;        // Flash lit time
	localparam int unsigned FLASH_OFF_MS    = 250;        // Dark between flashes
	localparam int unsigned GROUP_GAP_MS    = 2000;       // 2 s between groups
	localparam int unsigned POWERUP_RED_MS  = 500;        // Power-up red time

	// ****************************************
	// Fault codes (flash counts)
	// ****************************************
	localparam logic [3:0] CODE_NONE    = 4'h0;
	localparam logic [3:0] CODE_BUS_V   = 4'h2;
	localparam logic [3:0] CODE_OVER_I  = 4'h3;
	localparam logic [3:0] CODE_TEMP    = 4'h4;
	localparam logic [3:0] CODE_POS_ERR = 4'h5;
	localparam logic [3:0] CODE_VEL     = 4'h6;
	localparam logic [3:0] CODE_ERR_RT  = 4'h7;
	localparam logic [3:0] CODE_HW_POS  = 4'h8;
	localparam logic [3:0] CODE_HW_NEG  = 4'h9;
	localparam logic [3:0] CODE_SW_POS  = 4'ha;
	localparam logic [3:0] CODE_SW_NEG  = 4'hb;
	localparam logic [3:0] WDOG_FLASHES = 4'h3;       // Triple red flash

	// Fault input bit positions, in priority order low to high index
	localparam int unsigned FB_BUS_V   = 0;
	localparam int unsigned FB_OVER_I  = 1;
	localparam int unsigned FB_TEMP    = 2;
	localparam int unsigned FB_POS_ERR = 3;
	localparam int unsigned FB_VEL     = 4;
	localparam int unsigned FB_ERR_RT  = 5;
	localparam int unsigned FB_HW_POS  = 6;
	localparam int unsigned FB_HW_NEG  = 7;
	localparam int unsigned FB_SW_POS  = 8;
	localparam int unsigned FB_SW_NEG  = 9;
	localparam int unsigned FAULT_W    = 10;

	// Lamp colour pair
	typedef struct packed {
		logic green;
		logic red;
	} msli_lamp_type;

	// Drive status inputs
	typedef struct packed {
		logic               power_ok;
		logic               drive_on;
		logic               drive_enable;
		logic               watchdog_fault;
		logic               traj_active;
		logic               program_present;
		logic               program_limits_off;
		logic [FAULT_W-1:0] faults;
	} msli_drive_type;

	// Usb status inputs
	typedef struct packed {
		logic bus_power;
		logic configured;
		logic suspended;
		logic active;
	} msli_usb_type;

endpackage

// ---- src/msli_prescaler.sv ----
`timescale 1ns/1ps
// ****************************************
// Millisecond tick and slow toggles
// ****************************************
module msli_prescaler #(
	parameter int unsigned TICK_CYC = msli_pkg::TICK_CYC
) (
	input  wire logic ref_clk,
	input  wire logic srst,
	output logic      ms_tick,
	output logic      flicker,
	output logic      blink
);
	// Refuse a tick too short for the counter chain
	if (TICK_CYC < 2) begin
		$error("TICK_CYC too small");
	end

	// Whole state of the prescaler
	typedef struct packed {
		logic [31:0] cyc;
		logic [15:0] fl_ms;
		logic [15:0] bl_ms;
		logic        tick;
		logic        fl;
		logic        bl;
	} msli_pre_type;

	msli_pre_type st_r;   // Registered state
	msli_pre_type st_nxt; // Next state

	// Counter chain; reset clears everything
	always_comb begin
		st_nxt      = st_r;
		st_nxt.tick = 1'b0;
		// RL17 prescaled tick
		if (st_r.cyc == 32'(TICK_CYC - 1)) begin
			st_nxt.cyc  = '0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.cyc = st_r.cyc + 32'h1;
		end
		if (st_r.tick) begin
			// RL1 flicker toggle
			if (st_r.fl_ms == 16'(msli_pkg::FLICKER_MS - 1)) begin
				st_nxt.fl_ms = '0;
				st_nxt.fl    = ~st_r.fl;
			end else begin
				st_nxt.fl_ms = st_r.fl_ms + 16'h1;
			end
			// RL2 blink toggle
			if (st_r.bl_ms == 16'(msli_pkg::BLINK_MS - 1)) begin
				st_nxt.bl_ms = '0;
				st_nxt.bl    = ~st_r.bl;
			end else begin
				st_nxt.bl_ms = st_r.bl_ms + 16'h1;
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ms_tick = st_r.tick;
	assign flicker = st_r.fl;
	assign blink   = st_r.bl;
endmodule

// ---- src/msli_flasher.sv ----
`timescale 1ns/1ps
// ****************************************
// Repeating flash-group generator
// ****************************************
module msli_flasher (
	input  wire logic       ref_clk,
	input  wire logic       srst,
	input  wire logic       ms_tick,
	input  wire logic [3:0] count,
	output logic            lamp
);
	typedef enum logic [1:0] {
		FS_GAP,
		FS_ON,
		FS_OFF
	} msli_fstate_type;

	// Whole state of the flasher
	typedef struct packed {
		msli_fstate_type st;
		logic [15:0]     ms;
		logic [3:0]      done;
		logic            lit;
	} msli_fl_type;

	msli_fl_type f_r;   // Registered state
	msli_fl_type f_nxt; // Next state

	// Gap, then count flashes, then gap again
	always_comb begin
		f_nxt = f_r;
		if (count == 4'h0) begin
			// Idle: restart with a full gap
			f_nxt.st   = FS_GAP;
			f_nxt.ms   = '0;
			f_nxt.done = '0;
			f_nxt.lit  = 1'b0;
		end else if (ms_tick) begin
			f_nxt.ms = f_r.ms + 16'h1;
			unique case (f_r.st)
				// RL3 two second gap
				FS_GAP: begin
					f_nxt.lit = 1'b0;
					if (f_r.ms == 16'(msli_pkg::GROUP_GAP_MS - 1)) begin
						f_nxt.st  = FS_ON;
						f_nxt.ms  = '0;
						f_nxt.lit = 1'b1;
					end
				end
				FS_ON: begin
					if (f_r.ms == 16'(msli_pkg::FLASH_ON_MS - 1)) begin
						f_nxt.st   = FS_OFF;
						f_nxt.ms   = '0;
						f_nxt.lit  = 1'b0;
						f_nxt.done = f_r.done + 4'h1;
					end
				end
				FS_OFF: begin
					if (f_r.ms == 16'(msli_pkg::FLASH_OFF_MS - 1)) begin
						f_nxt.ms = '0;
						// RL18 repeat the group
						if (f_r.done >= count) begin
							f_nxt.st   = FS_GAP;
							f_nxt.done = '0;
						end else begin
							f_nxt.st  = FS_ON;
							f_nxt.lit = 1'b1;
						end
					end
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			f_r <= '{st: FS_GAP, ms: '0, done: '0, lit: 1'b0};
		end else begin
			f_r <= f_nxt;
		end
	end

	assign lamp = f_r.lit;
endmodule

// ---- src/msli_status_leds.sv ----
`timescale 1ns/1ps
// ****************************************
// Status lamp driver
// ****************************************
module msli_status_leds #(
	parameter int unsigned TICK_CYC = msli_pkg::TICK_CYC
) (
	input  wire logic                     ref_clk,
	input  wire logic                     srst,
	input  wire msli_pkg::msli_drive_type drive_in,
	input  wire msli_pkg::msli_usb_type   usb_in,
	output msli_pkg::msli_lamp_type       drive_indicator,
	output msli_pkg::msli_lamp_type       busy_indicator,
	output msli_pkg::msli_lamp_type       usb_indicator
);
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		PU_WAIT,
		PU_RED,
		PU_RUN
	} msli_pu_type;

	// Whole state of the top
	typedef struct packed {
		logic [2:0]                 pwr_s;   // Power pin sync
		logic [2:0]                 en_s;    // Enable pin sync
		logic [2:0]                 lim_s;   // Limit pins sync
		logic                       pwr_q;   // Qualified power
		logic                       en_q;    // Qualified enable
		logic                       lim_q;   // Qualified limits
		msli_pu_type                pu;      // Power-up phase
		logic [15:0]                pu_ms;   // Power-up red timer
		logic                       lim_flt; // Travel-limit fault
		msli_pkg::msli_lamp_type    drv;
		msli_pkg::msli_lamp_type    bsy;
		msli_pkg::msli_lamp_type    usb;
	} msli_top_type;

	msli_top_type s_r;   // Registered state
	msli_top_type s_nxt; // Next state

	logic       ms_tick;    // 1 ms enable
	logic       flicker;    // 0.1 s toggle
	logic       blink;      // 0.5 s toggle
	logic       code_lamp;  // Fault code flasher
	logic       wdog_lamp;  // Watchdog flasher
	logic [3:0] code;       // Active fault code
	logic [3:0] code_req;   // Code given to flasher
	logic [3:0] wdog_req;   // Watchdog request
	logic       latched;    // Any fault latched
	logic       red_steady; // Drive lamp steady red

	// ****************************************
	// Timing sources
	// ****************************************
	msli_prescaler #(
		.TICK_CYC(TICK_CYC)
	) u_pre (
		.ref_clk(ref_clk),
		.srst   (srst),
		.ms_tick(ms_tick),
		.flicker(flicker),
		.blink  (blink)
	);

	// Busy lamp code flasher
	msli_flasher u_code (
		.ref_clk(ref_clk),
		.srst   (srst),
		.ms_tick(ms_tick),
		.count  (code_req),
		.lamp   (code_lamp)
	);

	// Drive lamp watchdog flasher
	msli_flasher u_wdog (
		.ref_clk(ref_clk),
		.srst   (srst),
		.ms_tick(ms_tick),
		.count  (wdog_req),
		.lamp   (wdog_lamp)
	);

	// ****************************************
	// Fault code selection
	// ****************************************
	// Lowest code wins; code 1 never produced
	always_comb begin
		code = msli_pkg::CODE_NONE;
		// RL15 software negative limit
		if (drive_in.faults[msli_pkg::FB_SW_NEG])  code = msli_pkg::CODE_SW_NEG;
		// RL13 limit codes
		if (drive_in.faults[msli_pkg::FB_SW_POS])  code = msli_pkg::CODE_SW_POS;
		if (drive_in.faults[msli_pkg::FB_HW_NEG])  code = msli_pkg::CODE_HW_NEG;
		if (drive_in.faults[msli_pkg::FB_HW_POS])  code = msli_pkg::CODE_HW_POS;
		// RL14 drive fault codes
		if (drive_in.faults[msli_pkg::FB_ERR_RT])  code = msli_pkg::CODE_ERR_RT;
		if (drive_in.faults[msli_pkg::FB_VEL])     code = msli_pkg::CODE_VEL;
		if (drive_in.faults[msli_pkg::FB_POS_ERR]) code = msli_pkg::CODE_POS_ERR;
		if (drive_in.faults[msli_pkg::FB_TEMP])    code = msli_pkg::CODE_TEMP;
		if (drive_in.faults[msli_pkg::FB_OVER_I])  code = msli_pkg::CODE_OVER_I;
		if (drive_in.faults[msli_pkg::FB_BUS_V])   code = msli_pkg::CODE_BUS_V;
	end

	// Latched fault includes power-up travel fault
	assign latched = (|drive_in.faults) || s_r.lim_flt;

	// RL6 steady red condition
	assign red_steady = s_r.pwr_q && (latched || !s_r.en_q) && !drive_in.watchdog_fault
		&& (s_r.pu == PU_RUN);

	// RL8 code only while drive lamp red
	assign code_req = (red_steady && (code != msli_pkg::CODE_NONE)) ? code
		: msli_pkg::CODE_NONE;

	// RL5 watchdog triple flash
	assign wdog_req = (s_r.pwr_q && drive_in.watchdog_fault && s_r.pu == PU_RUN)
		? msli_pkg::WDOG_FLASHES : msli_pkg::CODE_NONE;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		// Pins from other domains: three stages, last two agree
		s_nxt.pwr_s = {s_r.pwr_s[1:0], drive_in.power_ok};
		s_nxt.en_s  = {s_r.en_s[1:0],  drive_in.drive_enable};
		s_nxt.lim_s = {s_r.lim_s[1:0], drive_in.program_limits_off};
		if (s_r.pwr_s[2] == s_r.pwr_s[1]) s_nxt.pwr_q = s_r.pwr_s[2];
		if (s_r.en_s[2]  == s_r.en_s[1])  s_nxt.en_q  = s_r.en_s[2];
		if (s_r.lim_s[2] == s_r.lim_s[1]) s_nxt.lim_q = s_r.lim_s[2];

		// Power-up sequence
		unique case (s_r.pu)
			PU_WAIT: begin
				s_nxt.pu_ms = '0;
				if (s_r.pwr_q) begin
					// RL10 limits low, no program
					if (!drive_in.program_present && !s_r.lim_q) begin
						s_nxt.lim_flt = 1'b1;
						s_nxt.pu      = PU_RUN;
					end else begin
						// RL11 red then green
						s_nxt.pu = PU_RED;
					end
				end
			end
			PU_RED: begin
				// RL12 same 500 ms red
				if (ms_tick) begin
					if (s_r.pu_ms == 16'(msli_pkg::POWERUP_RED_MS - 1)) begin
						s_nxt.pu = PU_RUN;
					end else begin
						s_nxt.pu_ms = s_r.pu_ms + 16'h1;
					end
				end
			end
			PU_RUN: begin
				// Travel fault clears once limits go high
				if (s_r.lim_q) s_nxt.lim_flt = 1'b0;
			end
		endcase
		if (!s_r.pwr_q) begin
			s_nxt.pu      = PU_WAIT;
			s_nxt.lim_flt = 1'b0;
		end

		// Drive lamp
		s_nxt.drv = '0;
		// RL4 power states
		if (!s_r.pwr_q) begin
			s_nxt.drv = '0;
		end else if (s_r.pu != PU_RUN) begin
			s_nxt.drv.red = 1'b1;
		end else if (drive_in.watchdog_fault) begin
			s_nxt.drv.red = wdog_lamp;
		end else if (red_steady) begin
			s_nxt.drv.red = 1'b1;
		end else if (drive_in.drive_on) begin
			s_nxt.drv.green = 1'b1;
		end else begin
			s_nxt.drv.green = blink;
		end

		// Busy lamp
		s_nxt.bsy = '0;
		if (red_steady) begin
			// RL16 gap precedes each group
			s_nxt.bsy.red = code_lamp;
		end else if (s_r.pwr_q && s_r.pu == PU_RUN && drive_in.drive_on
			&& drive_in.traj_active) begin
			// RL7 moving shows green
			s_nxt.bsy.green = 1'b1;
		end

		// RL9 usb lamp states
		s_nxt.usb = '0;
		if (usb_in.bus_power) begin
			if (!usb_in.configured) begin
				s_nxt.usb.red = 1'b1;
			end else if (usb_in.suspended) begin
				s_nxt.usb.red = flicker;
			end else if (usb_in.active) begin
				s_nxt.usb.green = flicker;
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	// RL17 reset clears lamps
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_r <= '{pwr_s: '0, en_s: '0, lim_s: '0, pwr_q: 1'b0, en_q: 1'b0,
				lim_q: 1'b0, pu: PU_WAIT, pu_ms: '0, lim_flt: 1'b0,
				drv: '0, bsy: '0, usb: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign drive_indicator = s_r.drv;
	assign busy_indicator  = s_r.bsy;
	assign usb_indicator   = s_r.usb;
endmodule

// ---- verification/msli_status_leds_checker.sv ----
`timescale 1ns/1ps
// ******
// Lamp checker
// ******
module msli_status_leds_checker #(
	parameter int unsigned TICK_CYC = msli_pkg::TICK_CYC
) (
	input wire logic                     ref_clk,
	input wire logic                     srst,
	input wire msli_pkg::msli_drive_type drive_in,
	input wire msli_pkg::msli_usb_type   usb_in,
	input wire msli_pkg::msli_lamp_type  drive_indicator,
	input wire msli_pkg::msli_lamp_type  busy_indicator,
	input wire msli_pkg::msli_lamp_type  usb_indicator
);
	localparam int FLK = 100 * TICK_CYC;                   // Flicker half period
	localparam int BLK = 500 * TICK_CYC;                   // Blink half period
	localparam int OFF = msli_pkg::FLASH_OFF_MS * TICK_CYC; // Dark between flashes
	localparam int GAP = 2000 * TICK_CYC;                  // Group gap
	int   usb_run_r; // Usb green run so far
	int   drv_run_r; // Green run since drive off
	int   off_run_r; // Busy dark run so far
	logic usb_act;   // Usb link active
	logic no_fault;  // Nothing faulted
	assign usb_act  = usb_in.bus_power && usb_in.configured && usb_in.active && !usb_in.suspended;
	assign no_fault = drive_in.faults == '0 && !drive_in.watchdog_fault;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// Run counters; cleared by reset so no stale run survives
	always_ff @(posedge ref_clk) begin
		usb_run_r <= (srst || !usb_indicator.green) ? 0 : usb_run_r + 1;
		drv_run_r <= (srst || !drive_indicator.green || drive_in.drive_on) ? 0 : drv_run_r + 1;
		off_run_r <= (srst || busy_indicator.red) ? 0 : off_run_r + 1;
	end
	a_reset_dark: assert property ($fell(srst) |-> {drive_indicator, busy_indicator,
		usb_indicator} == 6'h0) else $error("lamp lit after reset");
	a_drive_dark: assert property ((!drive_in.power_ok) [*8] |=>
		drive_indicator == 2'h0) else $error("drive lamp lit without power");
	a_fault_red: assert property ((drive_in.power_ok && drive_in.faults != '0
		&& !drive_in.watchdog_fault) [*8] |=> drive_indicator == 2'h1) else $error("fault not red");
	a_wdog_no_green: assert property (drive_in.watchdog_fault [*8] |=>
		!drive_indicator.green) else $error("green during watchdog");
	a_busy_green: assert property (drive_in.drive_on && drive_in.drive_enable
		&& drive_in.traj_active && no_fault && drive_indicator == 2'h2
		|=> busy_indicator == 2'h2) else $error("busy not green");
	a_busy_idle: assert property (!drive_in.traj_active && no_fault
		|=> busy_indicator == 2'h0) else $error("busy lit when idle");
	a_busy_needs_red: assert property (busy_indicator.red |->
		drive_indicator == 2'h1) else $error("busy flash without drive red");
	a_usb_unconf: assert property (usb_in.bus_power && !usb_in.configured |=>
		usb_indicator == 2'h1) else $error("usb not steady red");
	a_flicker_len: assert property (usb_act && usb_indicator.green |->
		usb_run_r < FLK) else $error("flicker run too long");
	a_blink_len: assert property (!drive_in.drive_on && drive_indicator.green |->
		drv_run_r <= BLK + 8) else $error("blink run too long");
	a_code_gap: assert property ($rose(busy_indicator.red) |->
		off_run_r == OFF || off_run_r >= GAP) else $error("bad dark before flash");
	c_flash: cover property ($rose(busy_indicator.red));
	c_flicker: cover property (usb_act && $fell(usb_indicator.green));
	c_blink: cover property (!drive_in.drive_on && $fell(drive_indicator.green));
endmodule
bind msli_status_leds msli_status_leds_checker #(.TICK_CYC(TICK_CYC)) u_chk (
	.ref_clk(ref_clk), .srst(srst), .drive_in(drive_in), .usb_in(usb_in),
	.drive_indicator(drive_indicator), .busy_indicator(busy_indicator),
	.usb_indicator(usb_indicator));

// ---- verification/msli_lamp_watch.sv ----
`timescale 1ns/1ps
// ******
// Lamp viewer: run lengths and flash groups
// ******
module msli_lamp_watch #(
	parameter int GAP = 1000 // Dark run that ends a group
) (
	input wire logic ref_clk,
	input wire logic clr,
	input wire logic lamp,
	output int       last_on,
	output int       last_off,
	output int       grp
);
	int   run;   // Current run length
	int   edges; // Flashes in this group
	logic prev;  // Level last cycle
	// A run ends on any change; first group after clear is partial
	always @(posedge ref_clk) begin
		if (clr) begin
			last_on <= 0;
			last_off <= 0;
			grp <= 0;
			edges <= 0;
			run <= 0;
			prev <= 1'b0;
		end else if (lamp !== prev) begin
			if (prev)
				last_on <= run;
			else
				last_off <= run;
			// Long dark closes the group
			if (lamp && run > GAP) begin
				grp <= edges;
				edges <= 1;
			end else if (lamp) begin
				edges <= edges + 1;
			end
			run <= 1;
			prev <= lamp;
		end else begin
			run <= run + 1;
		end
	end
endmodule

// ---- verification/msli_status_leds_tb.sv ----
`timescale 1ns/1ps
module msli_status_leds_tb;
	localparam int TK  = 2;        // Cycles per ms, shortened
	localparam int FLK = 100 * TK; // Flicker half period
	localparam int BLK = 500 * TK; // Blink half period
	logic                    ref_clk   = 1'b0;
	logic                    srst      = 1'b1;
	msli_pkg::msli_drive_type drive_in = '0;
	msli_pkg::msli_usb_type   usb_in   = '0;
	msli_pkg::msli_lamp_type  drive_indicator;
	msli_pkg::msli_lamp_type  busy_indicator;
	msli_pkg::msli_lamp_type  usb_indicator;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc       = 0;
	int dg_on, dg_off, dr_on, dr_grp, br_on, br_off, br_grp, ug_on, ug_off, ur_on;
	// ******
	// Clock, dut and lamp viewers
	// ******
	always #4 ref_clk = ~ref_clk;
	msli_status_leds #(.TICK_CYC(TK)) u_dut (.ref_clk(ref_clk), .srst(srst),
		.drive_in(drive_in), .usb_in(usb_in), .drive_indicator(drive_indicator),
		.busy_indicator(busy_indicator), .usb_indicator(usb_indicator));
	msli_lamp_watch #(.GAP(1000 * TK)) u_dg (.ref_clk(ref_clk), .clr(srst),
		.lamp(drive_indicator.green), .last_on(dg_on), .last_off(dg_off), .grp());
	msli_lamp_watch #(.GAP(1000 * TK)) u_dr (.ref_clk(ref_clk), .clr(srst),
		.lamp(drive_indicator.red), .last_on(dr_on), .last_off(), .grp(dr_grp));
	msli_lamp_watch #(.GAP(1000 * TK)) u_br (.ref_clk(ref_clk), .clr(srst),
		.lamp(busy_indicator.red), .last_on(br_on), .last_off(br_off), .grp(br_grp));
	msli_lamp_watch #(.GAP(1000 * TK)) u_ug (.ref_clk(ref_clk), .clr(srst),
		.lamp(usb_indicator.green), .last_on(ug_on), .last_off(ug_off), .grp());
	msli_lamp_watch #(.GAP(1000 * TK)) u_ur (.ref_clk(ref_clk), .clr(srst),
		.lamp(usb_indicator.red), .last_on(ur_on), .last_off(), .grp());
	// ******
	// Tasks
	// ******
	// Verdict and end of run
	task automatic print_verdict();
		if (error_cnt == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Compare and report
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// Inputs change 1 ns after an edge, apart from the first set at time 0
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// Reset with a given program and limit state
	task automatic power_up(input logic pp, input logic lo);
		srst = 1'b1;
		drive_in = '0;
		drive_in.power_ok = 1'b1;
		drive_in.drive_enable = 1'b1;
		drive_in.program_present = pp;
		drive_in.program_limits_off = lo;
		wait_cyc(5);
		check({drive_indicator, busy_indicator, usb_indicator}, 32'h0);
		srst = 1'b0;
	endtask
	// Hang guard; run needs about 53k cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 70000) begin
			error_cnt++;
			print_verdict();
		end
	end
	// ******
	// Sequence
	// ******
	initial begin
		// Program present, then absent, limits high
		for (int i = 0; i < 2; i++) begin
			power_up(i == 0, 1'b1);
			wait_cyc(2600 * TK);
			check(dr_on >= 500 * TK && dr_on <= 500 * TK + 16, 32'h1);
			check(dg_on, BLK);
			check(dg_off, BLK);
			check(busy_indicator, 32'h0);
		end
		// Usb: unconfigured, active, suspended
		usb_in = 4'h8;
		wait_cyc(4);
		check(usb_indicator, 32'h1);
		usb_in = 4'hd;
		wait_cyc(350 * TK);
		check(ug_on, FLK);
		check(ug_off, FLK);
		usb_in = 4'he;
		wait_cyc(350 * TK);
		check(ur_on, FLK);
		check(usb_indicator.green, 32'h0);
		// Drive on and moving, then idle, then no enable
		drive_in.drive_on = 1'b1;
		drive_in.traj_active = 1'b1;
		wait_cyc(10);
		check(drive_indicator, 32'h2);
		check(busy_indicator, 32'h2);
		drive_in.traj_active = 1'b0;
		wait_cyc(10);
		check(busy_indicator, 32'h0);
		drive_in.drive_enable = 1'b0;
		wait_cyc(10);
		check(drive_indicator, 32'h1);
		drive_in.drive_enable = 1'b1;
		// Code 11 alone, cut once its first group is over
		drive_in.faults[msli_pkg::FB_SW_NEG] = 1'b1;
		wait_cyc(7600 * TK);
		drive_in.faults = '0;
		wait_cyc(1);
		// Two faults: lower code wins, group repeats
		drive_in.faults[msli_pkg::FB_OVER_I] = 1'b1;
		drive_in.faults[msli_pkg::FB_TEMP] = 1'b1;
		// First group of the new code closes the code 11 count
		wait_cyc(2100 * TK);
		check(br_grp, 32'hb);
		// Stop between first and second flash of group two
		wait_cyc(3700 * TK);
		check(br_grp, 32'h3);
		check(br_on, 250 * TK);
		check(br_off >= 2000 * TK && br_off <= 2250 * TK, 32'h1);
		check(drive_indicator, 32'h1);
		// Watchdog: triple red flash, busy dark
		drive_in.faults = '0;
		drive_in.watchdog_fault = 1'b1;
		wait_cyc(6000 * TK);
		check(dr_grp, 32'h3);
		check(busy_indicator.red, 32'h0);
		// No program, limits low: travel fault
		power_up(1'b0, 1'b0);
		wait_cyc(1000 * TK);
		check(drive_indicator, 32'h1);
		check(busy_indicator, 32'h0);
		drive_in.power_ok = 1'b0;
		wait_cyc(20);
		check(drive_indicator, 32'h0);
		print_verdict();
	end
endmodule
